// ---- hw/baeq_top.v ----
// Bus activity event qualifier top with AXI4-Lite register slave
`include "baeq_consts.vh"
`default_nettype none
module baeq_top #(
  parameter TALLY_W = 32
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [31:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  // Bus reservation indications
  input wire reserve_own_drive,
  input wire reserve_sampled_here,
  input wire reserve_not_sampled,
  // Data ready pair, watched for clashes only
  input wire ready_sampled_here,
  input wire ready_not_sampled,
  // Bus queue allocation
  input wire alloc_valid,
  input wire [1:0] alloc_kind,
  input wire [1:0] alloc_size,
  input wire alloc_io,
  input wire alloc_lock,
  input wire alloc_cache,
  input wire alloc_split,
  input wire req_is_demand,
  // Counter increments
  output wire data_incr,
  output wire alloc_incr
);

  // Software registers
  reg [31:0] data_event_select;
  reg [31:0] data_counter_config;
  reg [31:0] alloc_event_select;
  reg [31:0] alloc_counter_config;
  reg [TALLY_W-1:0] data_tally;
  reg [TALLY_W-1:0] alloc_tally;
  reg [1:0] clash_status;

  // Write channel holding
  reg aw_held;
  reg [31:0] aw_addr;
  reg w_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire aw_take;
  wire w_take;
  wire ar_take;
  wire do_write;
  wire [3:0] wr_index;
  wire [3:0] rd_index;
  wire wr_mapped;
  wire [31:0] byte_mask;

  reg [31:0] next_rdata;
  reg [1:0] next_rresp;

  wire data_enable;
  wire alloc_enable;
  wire [1:0] clash_now;
  wire [1:0] clash_clear;

  // Address and data each ready while their own half is not held, reads while no answer waits; protection bits are not checked
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready = ~w_held;
  assign s_axi_arready = ~s_axi_rvalid;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  // Commit only once both halves are in and the last answer is gone
  assign do_write = aw_held & w_held & ~s_axi_bvalid;

  assign wr_index = aw_addr[`BAEQ_ADDR_MSB:`BAEQ_ADDR_LSB];
  assign rd_index = s_axi_araddr[`BAEQ_ADDR_MSB:`BAEQ_ADDR_LSB];
  assign wr_mapped = (aw_addr[31:`BAEQ_ADDR_MSB+1] == 26'h0) & (wr_index <= `BAEQ_OFS_STATUS);

  // Byte lane enables widen to a bit mask
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign byte_mask[lane*8+7:lane*8] = {8{w_strb[lane]}};
    end
  endgenerate

  // Capture address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h0;
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Register writes; tallies and status are read-only apart from clearing
  always @(posedge aclk) begin
    if (!aresetn) begin
      data_event_select <= 32'h0;
      data_counter_config <= 32'h0;
      alloc_event_select <= 32'h0;
      alloc_counter_config <= 32'h0;
    end else if (do_write && wr_mapped) begin
      case (wr_index)
        `BAEQ_OFS_DATA_SEL: data_event_select <= (data_event_select & ~byte_mask) | (w_data & byte_mask);
        `BAEQ_OFS_DATA_CFG: data_counter_config <= (data_counter_config & ~byte_mask) | (w_data & byte_mask);
        `BAEQ_OFS_ALLOC_SEL: alloc_event_select <= (alloc_event_select & ~byte_mask) | (w_data & byte_mask);
        `BAEQ_OFS_ALLOC_CFG: alloc_counter_config <= (alloc_counter_config & ~byte_mask) | (w_data & byte_mask);
        default: begin
        end
      endcase
    end
  end

  // Write response; unmapped addresses answer with a slave error
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BAEQ_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? `BAEQ_RESP_OKAY : `BAEQ_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read mux
  always @* begin
    next_rdata = 32'h0;
    next_rresp = `BAEQ_RESP_OKAY;
    if (s_axi_araddr[31:`BAEQ_ADDR_MSB+1] != 26'h0) begin
      next_rresp = `BAEQ_RESP_SLVERR;
    end else begin
      case (rd_index)
        `BAEQ_OFS_DATA_SEL: next_rdata = data_event_select;
        `BAEQ_OFS_DATA_CFG: next_rdata = data_counter_config;
        `BAEQ_OFS_ALLOC_SEL: next_rdata = alloc_event_select;
        `BAEQ_OFS_ALLOC_CFG: next_rdata = alloc_counter_config;
        `BAEQ_OFS_DATA_TALLY: next_rdata = data_tally;
        `BAEQ_OFS_ALLOC_TALLY: next_rdata = alloc_tally;
        `BAEQ_OFS_STATUS: next_rdata = {30'h0, clash_status};
        default: next_rresp = `BAEQ_RESP_SLVERR;
      endcase
    end
  end

  // Read answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `BAEQ_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Each event runs only when both its select codes are programmed
  assign data_enable = (data_event_select[`BAEQ_SEL_MSB:`BAEQ_SEL_LSB] == `BAEQ_DATA_EVT)
    & (data_counter_config[`BAEQ_CSEL_MSB:`BAEQ_CSEL_LSB] == `BAEQ_DATA_CSEL);
  assign alloc_enable = (alloc_event_select[`BAEQ_SEL_MSB:`BAEQ_SEL_LSB] == `BAEQ_ALLOC_EVT)
    & (alloc_counter_config[`BAEQ_CSEL_MSB:`BAEQ_CSEL_LSB] == `BAEQ_ALLOC_CSEL);

  baeq_data_qual u_data_qual (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(data_enable),
    .edge_mode(data_counter_config[`BAEQ_EDGE_BIT]),
    .mask(data_event_select[`BAEQ_MASK_MSB:`BAEQ_MASK_LSB]),
    .reserve_own_drive(reserve_own_drive),
    .reserve_sampled_here(reserve_sampled_here),
    .reserve_not_sampled(reserve_not_sampled),
    .incr(data_incr)
  );

  baeq_alloc_qual u_alloc_qual (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(alloc_enable),
    .mask(alloc_event_select[`BAEQ_MASK_MSB:`BAEQ_MASK_LSB]),
    .alloc_valid(alloc_valid),
    .alloc_kind(alloc_kind),
    .alloc_size(alloc_size),
    .alloc_io(alloc_io),
    .alloc_lock(alloc_lock),
    .alloc_cache(alloc_cache),
    .alloc_split(alloc_split),
    .req_is_demand(req_is_demand),
    .incr(alloc_incr)
  );

  // A clashing pair is a bus fault worth flagging to software
  assign clash_now[`BAEQ_ST_RESERVE_CLASH] = reserve_sampled_here & reserve_not_sampled;
  assign clash_now[`BAEQ_ST_READY_CLASH] = ready_sampled_here & ready_not_sampled;
  assign clash_clear = (do_write && wr_mapped && wr_index == `BAEQ_OFS_STATUS && w_strb[0]) ?
    w_data[1:0] : 2'h0;

  // Sticky flags, write one to clear; a new clash beats the clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      clash_status <= 2'h0;
    end else begin
      clash_status <= (clash_status & ~clash_clear) | clash_now;
    end
  end

  // Running tallies of emitted pulses; cleared by any write to them
  always @(posedge aclk) begin
    if (!aresetn) begin
      data_tally <= {TALLY_W{1'b0}};
      alloc_tally <= {TALLY_W{1'b0}};
    end else begin
      if (do_write && wr_mapped && wr_index == `BAEQ_OFS_DATA_TALLY) begin
        data_tally <= {TALLY_W{1'b0}};
      end else if (data_incr) begin
        data_tally <= data_tally + {{(TALLY_W-1){1'b0}}, 1'b1};
      end
      if (do_write && wr_mapped && wr_index == `BAEQ_OFS_ALLOC_TALLY) begin
        alloc_tally <= {TALLY_W{1'b0}};
      end else if (alloc_incr) begin
        alloc_tally <= alloc_tally + {{(TALLY_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule
`default_nettype wire

// ---- hw/baeq_consts.vh ----
// Register map, field positions and event codes of the bus activity event qualifier
`ifndef BAEQ_CONSTS_VH
`define BAEQ_CONSTS_VH

// Register word indices, taken from address bits 5:2
`define BAEQ_OFS_DATA_SEL 4'h0
`define BAEQ_OFS_DATA_CFG 4'h1
`define BAEQ_OFS_ALLOC_SEL 4'h2
`define BAEQ_OFS_ALLOC_CFG 4'h3
`define BAEQ_OFS_DATA_TALLY 4'h4
`define BAEQ_OFS_ALLOC_TALLY 4'h5
`define BAEQ_OFS_STATUS 4'h6
`define BAEQ_ADDR_LSB 2
`define BAEQ_ADDR_MSB 5

// Event select field and mask field
`define BAEQ_SEL_MSB 31
`define BAEQ_SEL_LSB 25
`define BAEQ_MASK_MSB 24
`define BAEQ_MASK_LSB 9
`define BAEQ_MASK_W 16

// Counter configuration select field and edge enable
`define BAEQ_CSEL_MSB 15
`define BAEQ_CSEL_LSB 13
`define BAEQ_EDGE_BIT 18

// Event codes
`define BAEQ_DATA_EVT 7'h17
`define BAEQ_DATA_CSEL 3'h6
`define BAEQ_ALLOC_EVT 7'h05
`define BAEQ_ALLOC_CSEL 3'h7

// Data activity mask bits
`define BAEQ_M_OWN_DRIVE 3
`define BAEQ_M_SAMPLED 4
`define BAEQ_M_NOT_SAMPLED 5

// Allocation mask bits
`define BAEQ_M_KIND_MSB 1
`define BAEQ_M_KIND_LSB 0
`define BAEQ_M_SIZE_MSB 3
`define BAEQ_M_SIZE_LSB 2
`define BAEQ_M_IO 5
`define BAEQ_M_LOCK 6
`define BAEQ_M_CACHE 7
`define BAEQ_M_SPLIT 8
`define BAEQ_M_DEMAND 9

// Status bits
`define BAEQ_ST_RESERVE_CLASH 0
`define BAEQ_ST_READY_CLASH 1

// Bus responses
`define BAEQ_RESP_OKAY 2'h0
`define BAEQ_RESP_SLVERR 2'h2

`endif

// ---- hw/baeq_data_qual.v ----
// Data reservation activity qualifier: mask bits to increment pulses
`include "baeq_consts.vh"
`default_nettype none
module baeq_data_qual (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Configuration
  input wire enable,
  input wire edge_mode,
  input wire [`BAEQ_MASK_W-1:0] mask,
  // Bus reservation indications
  input wire reserve_own_drive,
  input wire reserve_sampled_here,
  input wire reserve_not_sampled,
  // Counter side
  output reg incr
);

  reg hit_prev;
  wire not_sampled_eff;
  wire hit;

  // Sampled and not-sampled never count together; sampled wins
  assign not_sampled_eff = reserve_not_sampled & ~reserve_sampled_here;

  // Any selected indication that stands makes the cycle a hit, not-sampled only without sampled here; several in one cycle still give one
  assign hit = enable & ((mask[`BAEQ_M_OWN_DRIVE] & reserve_own_drive)
    | (mask[`BAEQ_M_SAMPLED] & reserve_sampled_here)
    | (mask[`BAEQ_M_NOT_SAMPLED] & not_sampled_eff));

  // Level or edge counting; edge mode merges a multi-cycle burst into one count
  always @(posedge aclk) begin
    if (!aresetn) begin
      hit_prev <= 1'b0;
      incr <= 1'b0;
    end else begin
      hit_prev <= hit;
      incr <= hit & ~(edge_mode & hit_prev);
    end
  end

endmodule
`default_nettype wire

// ---- hw/baeq_alloc_qual.v ----
// Bus queue allocation qualifier: matches each allocation against the mask
`include "baeq_consts.vh"
`default_nettype none
module baeq_alloc_qual (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Configuration
  input wire enable,
  input wire [`BAEQ_MASK_W-1:0] mask,
  // Allocation attributes
  input wire alloc_valid,
  input wire [1:0] alloc_kind,
  input wire [1:0] alloc_size,
  input wire alloc_io,
  input wire alloc_lock,
  input wire alloc_cache,
  input wire alloc_split,
  input wire req_is_demand,
  // Counter side
  output reg incr
);

  wire kind_ok;
  wire size_ok;
  wire flags_ok;
  wire demand_ok;

  // Kind: 0 read, 1 read-invalidate, 2 plain write, 3 writeback
  assign kind_ok = alloc_kind == mask[`BAEQ_M_KIND_MSB:`BAEQ_M_KIND_LSB];
  // Size: 0 no chunk, 1 one chunk, 3 eight chunks
  assign size_ok = alloc_size == mask[`BAEQ_M_SIZE_MSB:`BAEQ_M_SIZE_LSB];
  // A set flag demands the attribute; a clear one leaves it free
  assign flags_ok = (~mask[`BAEQ_M_IO] | alloc_io)
    & (~mask[`BAEQ_M_LOCK] | alloc_lock)
    & (~mask[`BAEQ_M_CACHE] | alloc_cache)
    & (~mask[`BAEQ_M_SPLIT] | alloc_split);
  // Set selects demand, clear selects prefetch
  assign demand_ok = req_is_demand == mask[`BAEQ_M_DEMAND];

  // One pulse per matching allocation
  always @(posedge aclk) begin
    if (!aresetn) begin
      incr <= 1'b0;
    end else begin
      incr <= enable & alloc_valid & kind_ok & size_ok & flags_ok & demand_ok;
    end
  end

endmodule
`default_nettype wire

// ---- dv/baeq_fsb_model.sv ----
// Bus agent and queue model driving reservations and allocations
`default_nettype none
module baeq_fsb_model (
  // Clock
  input wire logic aclk,
  // Reservation lines: own drive, sampled here, not sampled
  output logic [2:0] rsv,
  // Data ready pair: sampled here, not sampled
  output logic [1:0] rdy,
  // Allocation: kind, size, io, lock, cache, split, demand
  output logic a_valid,
  output logic [8:0] a_attr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {rsv, rdy, a_valid, a_attr} = 15'h0;
  // Data ready pair for one cycle; both high is a bus fault
  task automatic ready_pair(input logic [1:0] which);
    @(posedge aclk) rdy <= which;
    @(posedge aclk) rdy <= 2'h0;
    repeat (3) @(posedge aclk);
  endtask
  // Held n bus clocks in a row, as a stalled bus repeats it
  task automatic reserve(input logic [2:0] which, input int n);
    repeat (n) @(posedge aclk) rsv <= which;
    @(posedge aclk) rsv <= 3'h0;
    repeat (3) @(posedge aclk);
  endtask
  // One allocation; released attributes show the inverse, not stale data
  task automatic alloc(input logic [8:0] attr);
    @(posedge aclk) a_valid <= 1'b1;
    a_attr <= attr;
    @(posedge aclk) a_valid <= 1'b0;
    a_attr <= ~attr;
    repeat (3) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ---- dv/baeq_top_asserts.sv ----
// Port-level checks for the qualifier top
`default_nettype none
module baeq_top_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Qualifier link
  input wire logic reserve_own_drive,
  input wire logic reserve_sampled_here,
  input wire logic reserve_not_sampled,
  input wire logic alloc_valid,
  input wire logic data_incr,
  input wire logic alloc_incr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Responses parked on the master
  sequence b_wait; s_axi_bvalid && !s_axi_bready; endsequence
  sequence r_wait; s_axi_rvalid && !s_axi_rready; endsequence
  bvalid_hold_a: assert property (b_wait |=> s_axi_bvalid) else $error("bvalid dropped");
  rvalid_hold_a: assert property (r_wait |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready with rvalid");
  read_answer_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("rvalid without read");
  reset_idle_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !data_incr && !alloc_incr)
    else $error("busy after reset");
  data_cause_a: assert property (data_incr |-> $past(reserve_own_drive || reserve_sampled_here ||
    reserve_not_sampled)) else $error("data pulse without cause");
  alloc_cause_a: assert property (alloc_incr |-> $past(alloc_valid)) else $error("alloc pulse without cause");
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the qualifier top
`include "baeq_consts.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] awaddr, wdata, araddr;
  logic [3:0] wstrb;
  wire awready, wready, bvalid, arready, rvalid, data_incr, alloc_incr, av;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] rsv;
  wire [1:0] rdy;
  wire [8:0] at;
  int err_total = 0;
  int n_compared = 0;
  int n_dpulse = 0;
  int n_apulse = 0;
  // Pulses counted at the pins, apart from the tallies
  always @(posedge aclk) begin
    if (data_incr === 1'b1) n_dpulse <= n_dpulse + 1;
    if (alloc_incr === 1'b1) n_apulse <= n_apulse + 1;
  end
  baeq_top dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .reserve_own_drive(rsv[2]), .reserve_sampled_here(rsv[1]), .reserve_not_sampled(rsv[0]),
    .ready_sampled_here(rdy[1]), .ready_not_sampled(rdy[0]), .alloc_valid(av), .alloc_kind(at[8:7]),
    .alloc_size(at[6:5]), .alloc_io(at[4]), .alloc_lock(at[3]), .alloc_cache(at[2]), .alloc_split(at[1]),
    .req_is_demand(at[0]), .data_incr(data_incr), .alloc_incr(alloc_incr));
  baeq_fsb_model fsb (.aclk(aclk), .rsv(rsv), .rdy(rdy), .a_valid(av), .a_attr(at));
  // Clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic give_verdict();
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // A wait that ran out ends the run
  task automatic chk_to(input int n);
    if (n >= 50) begin
      err_total++;
      give_verdict();
    end
  endtask
  function automatic logic [31:0] ad(input logic [3:0] i);
    return {26'h0, i, 2'h0};
  endfunction
  function automatic logic [31:0] sel(input logic [6:0] c, input logic [15:0] m);
    return {c, m, 9'h0};
  endfunction
  function automatic logic [31:0] cfg(input logic e, input logic [2:0] cs);
    return {13'h0, e, 2'h0, cs, 13'h0};
  endfunction
  // Write: address and data offered together, each released once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    chk_to(n);
    cmp("bresp", 32'(er), 32'(bresp));
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    chk_to(n);
    cmp("rresp", 32'(er), 32'(rresp));
    if (er == `BAEQ_RESP_OKAY) cmp("rdata", ed, rdata);
  endtask
  // Reset values, readback, unmapped places, read-only tally
  task automatic t_regs();
    for (int i = 0; i < 7; i++) rd(ad(4'(i)), 32'h0, `BAEQ_RESP_OKAY);
    wr(ad(`BAEQ_OFS_ALLOC_SEL), 32'h5a5a_a5a5, `BAEQ_RESP_OKAY);
    rd(ad(`BAEQ_OFS_ALLOC_SEL), 32'h5a5a_a5a5, `BAEQ_RESP_OKAY);
    wstrb <= 4'h1;
    wr(ad(`BAEQ_OFS_ALLOC_SEL), 32'hffff_ffff, `BAEQ_RESP_OKAY);
    wstrb <= 4'hf;
    rd(ad(`BAEQ_OFS_ALLOC_SEL), 32'h5a5a_a5ff, `BAEQ_RESP_OKAY);
    wr(ad(4'h7), 32'h1, `BAEQ_RESP_SLVERR);
    rd(ad(4'h7), 32'h0, `BAEQ_RESP_SLVERR);
    rd(32'h40, 32'h0, `BAEQ_RESP_SLVERR);
    wr(ad(`BAEQ_OFS_DATA_TALLY), 32'h3, `BAEQ_RESP_OKAY);
    rd(ad(`BAEQ_OFS_DATA_TALLY), 32'h0, `BAEQ_RESP_OKAY);
  endtask
  // Each reservation mask bit against its own line and one other; wrong line never counts
  task automatic t_data();
    logic [31:0] t = ad(`BAEQ_OFS_DATA_TALLY);
    wr(ad(`BAEQ_OFS_DATA_CFG), cfg(1'b0, `BAEQ_DATA_CSEL), `BAEQ_RESP_OKAY);
    wr(ad(`BAEQ_OFS_DATA_SEL), sel(`BAEQ_DATA_EVT, 16'h0008), `BAEQ_RESP_OKAY);
    fsb.reserve(3'h4, 2);
    fsb.reserve(3'h2, 3);
    rd(t, 32'h2, `BAEQ_RESP_OKAY);
    fsb.reserve(3'h4, 5);
    rd(t, 32'h7, `BAEQ_RESP_OKAY);
    wr(ad(`BAEQ_OFS_DATA_SEL), sel(`BAEQ_DATA_EVT, 16'h0010), `BAEQ_RESP_OKAY);
    fsb.reserve(3'h2, 2);
    fsb.reserve(3'h1, 4);
    rd(t, 32'h9, `BAEQ_RESP_OKAY);
    wr(ad(`BAEQ_OFS_DATA_SEL), sel(`BAEQ_DATA_EVT, 16'h0020), `BAEQ_RESP_OKAY);
    fsb.reserve(3'h1, 4);
    fsb.reserve(3'h4, 2);
    fsb.reserve(3'h3, 2);
    rd(t, 32'hd, `BAEQ_RESP_OKAY);
    wr(ad(`BAEQ_OFS_DATA_SEL), sel(`BAEQ_DATA_EVT, 16'h0030), `BAEQ_RESP_OKAY);
    fsb.reserve(3'h3, 2);
    rd(t, 32'hf, `BAEQ_RESP_OKAY);
    wr(ad(`BAEQ_OFS_DATA_CFG), cfg(1'b1, `BAEQ_DATA_CSEL), `BAEQ_RESP_OKAY);
    fsb.reserve(3'h2, 4);
    rd(t, 32'h10, `BAEQ_RESP_OKAY);
    cmp("data pulses", 32'h10, 32'(n_dpulse));
  endtask
  // Clash flags: set by a clashing pair, cleared by writing one on lane 0
  task automatic t_clash();
    logic [31:0] s = ad(`BAEQ_OFS_STATUS);
    rd(s, 32'h1, `BAEQ_RESP_OKAY);
    fsb.ready_pair(2'h2);
    rd(s, 32'h1, `BAEQ_RESP_OKAY);
    fsb.ready_pair(2'h3);
    rd(s, 32'h3, `BAEQ_RESP_OKAY);
    wr(s, 32'h1, `BAEQ_RESP_OKAY);
    rd(s, 32'h2, `BAEQ_RESP_OKAY);
    wstrb <= 4'he;
    wr(s, 32'h2, `BAEQ_RESP_OKAY);
    wstrb <= 4'hf;
    rd(s, 32'h2, `BAEQ_RESP_OKAY);
    wr(s, 32'h2, `BAEQ_RESP_OKAY);
    rd(s, 32'h0, `BAEQ_RESP_OKAY);
  endtask
  // Every kind with sizes 0, 1 and 3, then each attribute bit, then demand versus prefetch
  task automatic t_alloc();
    logic [31:0] t = ad(`BAEQ_OFS_ALLOC_TALLY);
    logic [31:0] a = ad(`BAEQ_OFS_ALLOC_SEL);
    int na = 0;
    wr(ad(`BAEQ_OFS_ALLOC_CFG), cfg(1'b0, `BAEQ_ALLOC_CSEL), `BAEQ_RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      for (int s = 0; s < 4; s++) begin
        if (s == 2) continue;
        wr(a, sel(`BAEQ_ALLOC_EVT, {6'h0, 1'b1, 5'h0, 2'(s), 2'(k)}), `BAEQ_RESP_OKAY);
        fsb.alloc({2'(k), 2'(s), 5'h01});
        fsb.alloc({2'(k + 1), 2'(s), 5'h01});
        fsb.alloc({2'(k), 2'(s + 1), 5'h01});
        na++;
        rd(t, 32'(na), `BAEQ_RESP_OKAY);
      end
    end
    for (int b = 0; b < 4; b++) begin
      wr(a, sel(`BAEQ_ALLOC_EVT, 16'h0200 | (16'h0020 << b)), `BAEQ_RESP_OKAY);
      fsb.alloc(9'h001);
      fsb.alloc(9'h001 | (9'h010 >> b));
      na++;
      rd(t, 32'(na), `BAEQ_RESP_OKAY);
    end
    wr(a, sel(`BAEQ_ALLOC_EVT, 16'h0000), `BAEQ_RESP_OKAY);
    fsb.alloc(9'h001);
    fsb.alloc(9'h000);
    rd(t, 32'(na + 1), `BAEQ_RESP_OKAY);
    cmp("alloc pulses", 32'(na + 1), 32'(n_apulse));
  endtask
  // Reset for five cycles, then the scenarios
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_data();
    t_clash();
    t_alloc();
    give_verdict();
  end
endmodule
bind baeq_top baeq_top_asserts chk (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .reserve_own_drive(reserve_own_drive), .reserve_sampled_here(reserve_sampled_here),
  .reserve_not_sampled(reserve_not_sampled), .alloc_valid(alloc_valid), .data_incr(data_incr),
  .alloc_incr(alloc_incr));
`default_nettype wire
